// ---- design/fbg_guard.sv ----
// Purpose: Flash block write guard with AXI4-Lite register port
// Assumes: Flash requests are same-clock logic; debug level is from a pin
// Notes:   Protection bits are set-only; only reset clears them
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

// Summary of operation
// - Each protection bit guards one 4 kB block; bit i covers block i
// - Erase or write to a protected block raises a hard fault
// - Full-flash erase with any bit set is blocked and faults
// - Device reset clears every protection bit
// - A set protection bit stays set until the next reset
// - Writing zero leaves a bit alone; writing one sets it
// - Protection is bypassed only in debug mode with bypass selected
// - Debug bypass is one bit, resets to one; one means bypass
// - High map holds regions 32 to 47 in bits 0 to 15
module fbg_guard
  import fbg_pkg::*;
#(
  parameter int ADDR_WIDTH = 20
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  debug_attached,
  input  wire logic                  req_valid,
  input  wire logic                  req_erase_all,
  input  wire logic [ADDR_WIDTH-1:0] req_addr,
  output logic                       fwd_valid,
  output logic                       fwd_erase_all,
  output logic [ADDR_WIDTH-1:0]      fwd_addr,
  output logic                       hard_fault
);

  initial begin
    if (ADDR_WIDTH < BLOCK_SHIFT + 6 || ADDR_WIDTH > 32) begin
      $error("fbg_guard: ADDR_WIDTH out of range");
    end
  end

  typedef struct packed {
    logic                  aw_held;
    logic [11:0]           aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [31:0]           map_low;
    logic [HIGH_BITS-1:0]  map_high;
    logic                  dbg_bypass;
    logic                  dbg_meta;
    logic                  dbg_sync;
    logic                  fwd_valid;
    logic                  fwd_erase_all;
    logic [ADDR_WIDTH-1:0] fwd_addr;
    logic                  fault;
  } fbg_state_type;

  fbg_state_type state;
  fbg_state_type next_state;

  // Flattened map and per-request decode
  logic [NUM_BLOCKS-1:0] prot_map;
  logic [5:0]            blk_idx;
  logic                  in_range;
  logic                  enforce;
  logic                  violation;
  logic                  do_write;
  logic [31:0]           wmask;

  assign prot_map = {state.map_high, state.map_low};
  assign blk_idx  = req_addr[BLOCK_SHIFT +: 6];
  assign in_range = (req_addr[ADDR_WIDTH-1:BLOCK_SHIFT] < NUM_BLOCKS);
  // Debug level is synchronised; only the second stage is read
  assign enforce  = !(state.dbg_sync && state.dbg_bypass);

  // Violation decode; blocks past the map are never protected
  always_comb begin
    violation = 1'b0;
    if (req_valid && enforce) begin
      if (req_erase_all) begin
        violation = |prot_map;
      end else if (in_range) begin
        violation = prot_map[blk_idx];
      end
    end
  end

  assign do_write = state.aw_held && state.w_held && !state.bvalid;

  // Byte-lane mask built once per lane
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wmask[8*g +: 8] = {8{state.w_strb[g]}};
    end
  endgenerate

  // Next-state logic for bus, map and request path
  always_comb begin
    next_state = state;
    next_state.dbg_meta = debug_attached;
    next_state.dbg_sync = state.dbg_meta;
    // Address and data may arrive in either order
    if (s_axi_awvalid && !state.aw_held) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state.w_held) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = RESP_OKAY;
      case ({state.aw_addr[11:2], 2'b00})
        ADDR_MAP_LOW: begin
          // OR-in only: zeros never clear a bit
          next_state.map_low = state.map_low
                               | (state.w_data & wmask);
        end
        ADDR_MAP_HIGH: begin
          next_state.map_high = state.map_high
                                | (state.w_data[HIGH_BITS-1:0]
                                   & wmask[HIGH_BITS-1:0]);
        end
        ADDR_DBG_BYPASS: begin
          if (state.w_strb[0]) begin
            next_state.dbg_bypass = state.w_data[0];
          end
        end
        ADDR_RESERVED: begin
          next_state.bresp = RESP_OKAY;
        end
        default: begin
          next_state.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    // Read path; reserved slot and unused bits read zero
    if (s_axi_arvalid && !state.rvalid) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = RESP_OKAY;
      next_state.rdata  = 32'h00000000;
      case ({s_axi_araddr[11:2], 2'b00})
        ADDR_MAP_LOW:    next_state.rdata = state.map_low;
        ADDR_MAP_HIGH:   next_state.rdata = {16'h0000, state.map_high};
        ADDR_DBG_BYPASS: next_state.rdata = {31'h0, state.dbg_bypass};
        ADDR_RESERVED:   next_state.rdata = 32'h00000000;
        default:         next_state.rresp = RESP_SLVERR;
      endcase
    end else if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    // Offending requests are dropped, so flash is untouched
    next_state.fwd_valid     = req_valid && !violation;
    next_state.fwd_erase_all = req_erase_all;
    next_state.fwd_addr      = req_addr;
    next_state.fault         = violation;
  end

  // One register stage; reset clears all protection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state            <= '0;
      state.map_low    <= RST_MAP;
      state.map_high   <= RST_MAP[HIGH_BITS-1:0];
      state.dbg_bypass <= RST_DBG_BYPASS;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_awready = !state.aw_held;
  assign s_axi_wready  = !state.w_held;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = !state.rvalid;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;
  assign fwd_valid     = state.fwd_valid;
  assign fwd_erase_all = state.fwd_erase_all;
  assign fwd_addr      = state.fwd_addr;
  assign hard_fault    = state.fault;

  // Checks kept beside the logic they guard
  a_fault_on_block: assert property (@(posedge aclk) disable iff (!aresetn)
    req_valid && !req_erase_all && in_range && prot_map[blk_idx] && enforce
    |=> hard_fault && !fwd_valid)
    else $error("protected block write not faulted");
  a_erase_all_block: assert property (@(posedge aclk) disable iff (!aresetn)
    req_valid && req_erase_all && (|prot_map) && enforce
    |=> hard_fault && !fwd_valid)
    else $error("erase-all passed with protection set");
  a_bits_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (($past(state.map_low) & ~state.map_low) == 32'h0))
    else $error("protection bit cleared without reset");
  a_reset_clears: assert property (@(posedge aclk)
    !aresetn |=> state.map_low == 32'h0 && state.map_high == 16'h0
    && state.dbg_bypass)
    else $error("reset did not clear map");
  a_bypass_debug: assert property (@(posedge aclk) disable iff (!aresetn)
    req_valid && !enforce |=> fwd_valid && !hard_fault)
    else $error("bypass in debug not honoured");
  a_no_fwd_fault: assert property (@(posedge aclk) disable iff (!aresetn)
    hard_fault |-> !fwd_valid)
    else $error("faulting request forwarded");
  a_high_unused: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && $past(s_axi_araddr[11:2]) == ADDR_MAP_HIGH[11:2]
    && $rose(s_axi_rvalid) |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper high-map bits not zero");
  a_set_one: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && state.aw_addr[11:2] == ADDR_MAP_LOW[11:2]
    && state.w_strb[0] && state.w_data[0] |=> state.map_low[0])
    else $error("write one did not set bit");

  // Upper map is as sticky as the lower one
  a_high_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (($past(state.map_high) & ~state.map_high) == 16'h0000))
    else $error("high map bit cleared without reset");
  a_high_set: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && state.aw_addr[11:2] == ADDR_MAP_HIGH[11:2]
    && state.w_strb[0] && state.w_data[0] |=> state.map_high[0])
    else $error("high map write one did not set bit");
  a_zero_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && state.aw_addr[11:2] == ADDR_MAP_LOW[11:2]
    && state.w_data == 32'h0 |=> $stable(state.map_low))
    else $error("zero write changed low map");

  // Bypass bit follows lane 0 writes only
  a_bypass_write: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && state.aw_addr[11:2] == ADDR_DBG_BYPASS[11:2]
    && state.w_strb[0] |=> state.dbg_bypass == $past(state.w_data[0]))
    else $error("bypass bit not written");
  a_bypass_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !state.dbg_bypass |-> enforce)
    else $error("protection off with bypass cleared");
  a_debug_needed: assert property (@(posedge aclk) disable iff (!aresetn)
    !state.dbg_sync |-> enforce)
    else $error("protection off outside debug");
  a_sync_stage: assert property (@(posedge aclk) disable iff (!aresetn)
    state.dbg_sync == $past(state.dbg_meta))
    else $error("debug level skipped a sync stage");

  // Request path answers exactly one cycle later
  a_fwd_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    req_valid && !violation
    |=> fwd_valid && fwd_addr == $past(req_addr))
    else $error("clean request not forwarded intact");
  a_fwd_erase: assert property (@(posedge aclk) disable iff (!aresetn)
    req_valid && !violation
    |=> fwd_erase_all == $past(req_erase_all))
    else $error("erase kind not forwarded intact");
  a_fault_only: assert property (@(posedge aclk) disable iff (!aresetn)
    !violation |=> !hard_fault)
    else $error("fault without a violation");
  a_idle_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !req_valid |=> !fwd_valid && !hard_fault)
    else $error("output without a request");
  a_range_free: assert property (@(posedge aclk) disable iff (!aresetn)
    req_valid && !req_erase_all && !in_range |=> !hard_fault)
    else $error("block past the map faulted");
  a_erase_free: assert property (@(posedge aclk) disable iff (!aresetn)
    req_valid && req_erase_all && !(|prot_map) |=> !hard_fault)
    else $error("erase-all faulted with no protection");

  // Responses stand until the master takes them
  a_b_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped early");
  a_b_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("write response missing");

  // Decode of the register window
  a_wr_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && state.aw_addr[11:4] != ADDR_MAP_LOW[11:4]
    |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_wr_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && state.aw_addr[11:2] == ADDR_RESERVED[11:2]
    |=> s_axi_bresp == RESP_OKAY && $stable(state.map_low))
    else $error("reserved write misbehaved");
  a_rd_low: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) && $past(s_axi_araddr[11:2]) == ADDR_MAP_LOW[11:2]
    |-> s_axi_rdata == $past(state.map_low))
    else $error("low map read wrong");
  a_rd_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid)
    && $past(s_axi_araddr[11:2]) == ADDR_DBG_BYPASS[11:2]
    |-> s_axi_rdata[31:1] == 31'h0)
    else $error("bypass read has extra bits");
  a_rd_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) && $past(s_axi_araddr[11:2]) == ADDR_RESERVED[11:2]
    |-> s_axi_rdata == 32'h0 && s_axi_rresp == RESP_OKAY)
    else $error("reserved slot read not zero");
  a_rd_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) && $past(s_axi_araddr[11:4]) != ADDR_MAP_LOW[11:4]
    |-> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");

endmodule : fbg_guard

// ---- design/fbg_pkg.sv ----
// Purpose: Constants for the flash block write guard
// Assumes: 32-bit AXI4-Lite register port, 4 kB flash blocks
// Notes:   Offsets are byte addresses within the guard's window
package fbg_pkg;
  localparam logic [11:0] ADDR_MAP_LOW     = 12'h600;
  localparam logic [11:0] ADDR_MAP_HIGH    = 12'h604;
  localparam logic [11:0] ADDR_DBG_BYPASS  = 12'h608;
  localparam logic [11:0] ADDR_RESERVED    = 12'h60c;
  localparam logic [31:0] RST_MAP          = 32'h00000000;
  localparam logic        RST_DBG_BYPASS   = 1'b1;
  localparam int          BLOCK_SHIFT      = 12;
  localparam int          NUM_BLOCKS       = 48;
  localparam int          HIGH_BITS        = 16;
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;
endpackage : fbg_pkg

// ---- verification/fbg_req_model.sv ----
// Purpose: Request source standing in for the CPU and flash controller
// Assumes: One request per cycle, launched on the rising edge
// Notes:   Idle lines toggle so a stale value is never trusted
`timescale 1ns/1ns
module fbg_req_model (
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic        all,
  input  wire logic [19:0] addr,
  output logic             req_valid,
  output logic             req_erase_all,
  output logic [19:0]      req_addr
);
  // One request per go; idle lines invert
  always_ff @(posedge aclk) begin
    req_valid     <= go;
    req_erase_all <= go ? all : ~req_erase_all;
    req_addr      <= go ? addr : ~req_addr;
  end
endmodule : fbg_req_model

// ---- verification/flash_block_write_guard_bench.sv ----
// Purpose: Self-checking bench for the flash block write guard
// Assumes: Bench drives on the rising edge, samples on the falling edge
// Notes:   Strobes stay full except in one lane-masking write
`timescale 1ns/1ns
module flash_block_write_guard_bench;
  import fbg_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, dbg, go, all;
  logic        req_valid, req_erase_all, fwd_valid, fwd_erase_all, fault;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  wstrb;
  logic [19:0] addr, req_addr, fwd_addr;
  int          error_cnt, n_tests;
  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;
  fbg_guard u_fbg_guard (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .debug_attached(dbg),
    .req_valid(req_valid), .req_erase_all(req_erase_all),
    .req_addr(req_addr), .fwd_valid(fwd_valid),
    .fwd_erase_all(fwd_erase_all), .fwd_addr(fwd_addr), .hard_fault(fault));
  fbg_req_model u_fbg_req_model (.aclk(aclk), .go(go), .all(all),
    .addr(addr), .req_valid(req_valid), .req_erase_all(req_erase_all),
    .req_addr(req_addr));
  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : check
  // One AXI4-Lite write (w=1) or read (w=0); response in r, data in v
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int  i;
    logic ta, tw, tr, tb;
    awaddr  <= a;
    araddr  <= a;
    wdata   <= d;
    awvalid <= w;
    wvalid  <= w;
    bready  <= w;
    arvalid <= !w;
    rready  <= !w;
    for (i = 0; i < 40; i++) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tr = arready;
      tb = (bvalid && bready) || (rvalid && rready);
      r  = w ? bresp : rresp;
      v  = rdata;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    // Let one edge pass so the next call never re-drives in this step
    @(posedge aclk);
    if (i == 40) begin
      error_cnt++;
      final_report();
    end
  endtask : bus
  // Issue one flash request and judge its one-cycle answer
  task automatic rq(input logic al, input logic [19:0] ad, input logic f);
    go   <= 1'b1;
    all  <= al;
    addr <= ad;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    @(negedge aclk);
    check("hard_fault", f, fault);
    check("fwd_valid", !f, fwd_valid);
    if (!f) check("fwd_erase_all", al, fwd_erase_all);
    if (!f && !al) check("fwd_addr", ad, fwd_addr);
    @(posedge aclk);
  endtask : rq
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset
  task automatic t_reset_vals();
    bus(1, ADDR_RESERVED, 32'hffffffff);
    check("rsv_wr_resp", RESP_OKAY, r);
    bus(1, 12'h700, 32'hffffffff);
    check("unmapped_wr", RESP_SLVERR, r);
    bus(0, ADDR_MAP_LOW, 0);
    check("map_low", RST_MAP, v);
    bus(0, ADDR_MAP_HIGH, 0);
    check("map_high", RST_MAP, v);
    bus(0, ADDR_DBG_BYPASS, 0);
    check("bypass", 32'h00000001, v);
    bus(0, ADDR_RESERVED, 0);
    check("reserved", 32'h00000000, {v[31:2], r});
    bus(0, 12'h700, 0);
    check("unmapped_resp", RESP_SLVERR, r);
    rq(0, 20'h02000, 0);
  endtask : t_reset_vals
  task automatic t_protect();
    bus(1, ADDR_MAP_LOW, 32'h00000005);
    check("bresp", RESP_OKAY, r);
    bus(1, ADDR_MAP_LOW, 32'h00000000);
    bus(0, ADDR_MAP_LOW, 0);
    check("map_low", 32'h00000005, v);
    wstrb <= 4'h2;
    bus(1, ADDR_MAP_LOW, 32'h00010100);
    wstrb <= 4'hf;
    check("strb_resp", RESP_OKAY, r);
    bus(0, ADDR_MAP_LOW, 0);
    check("map_low_strb", 32'h00000105, v);
    bus(1, ADDR_MAP_HIGH, 32'hffff0001);
    bus(0, ADDR_MAP_HIGH, 0);
    check("map_high", 32'h00000001, v);
    rq(0, 20'h02fff, 1);
    rq(0, 20'h03000, 0);
    rq(0, 20'h00000, 1);
    rq(0, 20'h01ffc, 0);
    rq(0, 20'h08000, 1);
    rq(0, 20'h20000, 1);
    rq(0, 20'h21000, 0);
    rq(1, 20'h03000, 1);
  endtask : t_protect
  task automatic t_debug();
    dbg <= 1'b1;
    repeat (4) @(posedge aclk);
    rq(0, 20'h02000, 0);
    rq(1, 20'h00000, 0);
    bus(1, ADDR_DBG_BYPASS, 32'h00000000);
    rq(0, 20'h02000, 1);
    bus(1, ADDR_DBG_BYPASS, 32'h00000001);
    dbg <= 1'b0;
    repeat (4) @(posedge aclk);
    rq(0, 20'h02000, 1);
  endtask : t_debug
  // Main sequence; a second reset proves protection clears
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {dbg, go, all, awaddr, araddr, wdata, addr} = '0;
    wstrb = 4'hf;
    error_cnt = 0;
    n_tests = 0;
    do_reset();
    t_protect();
    t_debug();
    do_reset();
    t_reset_vals();
    final_report();
  end
endmodule : flash_block_write_guard_bench
